// ==== bifd_cfg.svh ====
// Constants for the base integer format decoder
`ifndef BIFD_CFG_SVH
`define BIFD_CFG_SVH
`define BIFD_WORD_WIDTH     32
`define BIFD_NUM_REGS       32
`define BIFD_RESET_VECTOR   32'h0000_0000
`define BIFD_OPC_LO         0
`define BIFD_OPC_HI         6
`define BIFD_RD_LO          7
`define BIFD_RD_HI          11
`define BIFD_F3_LO          12
`define BIFD_F3_HI          14
`define BIFD_RS1_LO         15
`define BIFD_RS1_HI         19
`define BIFD_RS2_LO         20
`define BIFD_RS2_HI         24
`define BIFD_F7_LO          25
`define BIFD_F7_HI          31
`define BIFD_SIGN_BIT       31
`define BIFD_OPC_OP         7'h33
`define BIFD_OPC_OPIMM      7'h13
`define BIFD_OPC_LOAD       7'h03
`define BIFD_OPC_STORE      7'h23
`define BIFD_OPC_LUI        7'h37
`define BIFD_OPC_AUIPC      7'h17
`define BIFD_OPC_JAL        7'h6f
`define BIFD_OPC_JALR       7'h67
`define BIFD_OPC_BRANCH     7'h63
`define BIFD_OPC_MEMORY_ORDERING_BARRIER      7'h0f
`define BIFD_OPC_SYSTEM     7'h73
`define BIFD_F3_CSR_IMM_BIT 2
`endif

// ==== bifd_pkg.sv ====
// Types for the base integer format decoder
package bifd_pkg;
  typedef enum logic [2:0] {
    BIFD_FMT_R,
    BIFD_FMT_I,
    BIFD_FMT_S,
    BIFD_FMT_U,
    BIFD_FMT_CTL,
    BIFD_FMT_SYS,
    BIFD_FMT_NOP,
    BIFD_FMT_BAD
  } bifd_fmt_t;
endpackage

// ==== bifd_rf_if.sv ====
// Register file access bundle between decoder and storage
`timescale 1ns/100ps
interface bifd_rf_if;
  logic [4:0]  rd_addr_a;
  logic [4:0]  rd_addr_b;
  logic [31:0] rd_data_a;
  logic [31:0] rd_data_b;
  logic        wr_en;
  logic [4:0]  wr_addr;
  logic [31:0] wr_data;
  modport master (output rd_addr_a, output rd_addr_b, input rd_data_a, input rd_data_b,
                  output wr_en, output wr_addr, output wr_data);
  modport slave  (input rd_addr_a, input rd_addr_b, output rd_data_a, output rd_data_b,
                  input wr_en, input wr_addr, input wr_data);
endinterface

// ==== bifd_regfile.sv ====
// General register file with hardwired zero register
`timescale 1ns/100ps
`include "bifd_cfg.svh"
module bifd_regfile
  import bifd_pkg::*;
#(
  parameter int NREG = `BIFD_NUM_REGS,
  parameter int W    = `BIFD_WORD_WIDTH
) (
  input  wire logic clk,
  bifd_rf_if.slave  rf
);
  typedef struct packed {
    logic [NREG-1:1][W-1:0] regs;
  } bifd_rf_state_t;

  bifd_rf_state_t s_q;
  bifd_rf_state_t s_d;

  // No reset: contents other than the zero register are undefined
  always_comb begin
    s_d = s_q;
    if (rf.wr_en && rf.wr_addr != 5'h0) begin
      s_d.regs[rf.wr_addr] = rf.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rf.rd_data_a = (rf.rd_addr_a == 5'h0) ? '0 : s_q.regs[rf.rd_addr_a];
  assign rf.rd_data_b = (rf.rd_addr_b == 5'h0) ? '0 : s_q.regs[rf.rd_addr_b];

  a_zero_reads_zero: assert property (@(posedge clk)
    rf.rd_addr_a == 5'h0 |-> rf.rd_data_a == '0) else $error("zero register read nonzero");
  a_write_lands: assert property (@(posedge clk)
    rf.wr_en && rf.wr_addr != 5'h0 |=> rf.rd_addr_a != $past(rf.wr_addr) || rf.rd_data_a == $past(rf.wr_data))
    else $error("register write not visible");
endmodule

// ==== bifd_decode.sv ====
// Decode front end: fields, immediates, program counter, alignment check
`timescale 1ns/100ps
`include "bifd_cfg.svh"
module bifd_decode
  import bifd_pkg::*;
#(
  parameter int          W           = `BIFD_WORD_WIDTH,
  parameter bit          SHORT_INSNS = 1'b0,
  parameter logic [31:0] RESET_VEC   = `BIFD_RESET_VECTOR,
  parameter bit          RESERVED_IS_ILLEGAL = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        insn_valid,
  input  wire logic [31:0] insn,
  input  wire logic        xfer_valid,
  input  wire logic        xfer_taken,
  input  wire logic [31:0] xfer_target,
  input  wire logic        wb_en,
  input  wire logic [4:0]  wb_addr,
  input  wire logic [31:0] wb_data,
  output logic             dec_valid,
  output bifd_fmt_t        dec_fmt,
  output logic [6:0]       dec_opcode,
  output logic [4:0]       dec_rd,
  output logic [4:0]       dec_first_source_field,
  output logic [4:0]       dec_second_source_field,
  output logic [2:0]       dec_minor_function_field,
  output logic [6:0]       dec_major_function_field,
  output logic [31:0]      dec_imm,
  output logic [31:0]      dec_src_a,
  output logic [31:0]      dec_src_b,
  output logic [31:0]      dec_pc,
  output logic             dec_link_hint,
  output logic             exc_illegal,
  output logic             exc_trap_call,
  output logic             exc_misaligned,
  output logic [31:0]      exc_pc,
  output logic [31:0]      program_counter
);
  // ==========================================================
  // State
  typedef struct packed {
    logic        valid;
    bifd_fmt_t   fmt;
    logic [6:0]  opc;
    logic [4:0]  rd;
    logic [4:0]  rs_a;
    logic [4:0]  rs_b;
    logic [2:0]  f3;
    logic [6:0]  f7;
    logic [31:0] imm;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] dpc;
    logic        link;
    logic        illegal;
    logic        trap;
    logic        misal;
    logic [31:0] epc;
    logic [31:0] pc;
  } bifd_state_t;

  bifd_state_t s_q;
  bifd_state_t s_d;

  bifd_rf_if rf ();

  bifd_regfile #(
    .NREG (`BIFD_NUM_REGS),
    .W    (W)
  ) u_rf (
    .clk (clk),
    .rf  (rf)
  );

  // ==========================================================
  // Field extraction, format independent
  logic [4:0]  f_rd;
  logic [4:0]  f_rs_a;
  logic [4:0]  f_rs_b;
  logic [6:0]  f_opc;
  logic [2:0]  f_f3;
  logic [31:0] sgn;
  logic        align_bad;

  assign f_opc  = insn[`BIFD_OPC_HI:`BIFD_OPC_LO];
  assign f_rd   = insn[`BIFD_RD_HI:`BIFD_RD_LO];
  assign f_rs_a = insn[`BIFD_RS1_HI:`BIFD_RS1_LO];
  assign f_rs_b = insn[`BIFD_RS2_HI:`BIFD_RS2_LO];
  assign f_f3   = insn[`BIFD_F3_HI:`BIFD_F3_LO];
  // Sign replicated before the format is known, keeps it off the decode path
  assign sgn    = {32{insn[`BIFD_SIGN_BIT]}};

  assign rf.rd_addr_a = f_rs_a;
  assign rf.rd_addr_b = f_rs_b;
  assign rf.wr_en     = wb_en;
  assign rf.wr_addr   = wb_addr;
  assign rf.wr_data   = wb_data;

  // Bit 1 only matters when short instructions are absent
  assign align_bad = SHORT_INSNS ? xfer_target[0] : |xfer_target[1:0];

  // ==========================================================
  // Next state
  always_comb begin
    s_d         = s_q;
    s_d.valid   = insn_valid;
    s_d.misal   = 1'b0;
    s_d.illegal = 1'b0;
    s_d.trap    = 1'b0;
    if (insn_valid) begin
      s_d.opc   = f_opc;
      s_d.rd    = f_rd;
      s_d.rs_a  = f_rs_a;
      s_d.rs_b  = f_rs_b;
      s_d.f3    = f_f3;
      s_d.f7    = insn[`BIFD_F7_HI:`BIFD_F7_LO];
      s_d.src_a = rf.rd_data_a;
      s_d.src_b = rf.rd_data_b;
      s_d.dpc   = s_q.pc;
      s_d.link  = 1'b0;
      s_d.imm   = {sgn[31:12], insn[31:20]};
      case (f_opc)
        `BIFD_OPC_OP: begin
          s_d.fmt = BIFD_FMT_R;
          s_d.imm = '0;
        end
        `BIFD_OPC_OPIMM, `BIFD_OPC_LOAD: begin
          s_d.fmt = BIFD_FMT_I;
        end
        // Load/store alignment is left to the memory side
        `BIFD_OPC_STORE: begin
          s_d.fmt = BIFD_FMT_S;
          s_d.imm = {sgn[31:12], insn[31:25], insn[11:7]};
        end
        `BIFD_OPC_LUI, `BIFD_OPC_AUIPC: begin
          s_d.fmt = BIFD_FMT_U;
          s_d.imm = {insn[31:12], 12'h000};
        end
        `BIFD_OPC_JAL, `BIFD_OPC_JALR, `BIFD_OPC_BRANCH: begin
          s_d.fmt  = BIFD_FMT_CTL;
          s_d.link = (f_rd == 5'h01) || (f_rd == 5'h05) ||
                     (f_rs_a == 5'h01) || (f_rs_a == 5'h05);
        end
        `BIFD_OPC_MEMORY_ORDERING_BARRIER: begin
          s_d.fmt = BIFD_FMT_NOP;
          s_d.imm = '0;
        end
        `BIFD_OPC_SYSTEM: begin
          s_d.fmt = BIFD_FMT_SYS;
          if (f_f3 == 3'h0) begin
            s_d.trap = 1'b1;
          end else if (f_f3[`BIFD_F3_CSR_IMM_BIT]) begin
            s_d.imm = {27'h0, f_rs_a};
          end
        end
        default: begin
          s_d.fmt     = BIFD_FMT_BAD;
          s_d.illegal = RESERVED_IS_ILLEGAL;
        end
      endcase
      // Low opcode bits other than 2'b11 are not 32-bit instructions
      if (insn[1:0] != 2'h3) begin
        s_d.fmt     = BIFD_FMT_BAD;
        s_d.illegal = RESERVED_IS_ILLEGAL;
      end
    end
    // Resolved transfer: a misaligned taken target holds the pc, else it moves to the target or pc+4
    if (xfer_valid) begin
      if (xfer_taken && align_bad) begin
        s_d.misal = 1'b1;
        s_d.epc   = s_q.pc;
      end else if (xfer_taken) begin
        s_d.pc = xfer_target;
      end else begin
        s_d.pc = s_q.pc + 32'h0000_0004;
      end
    end else if (insn_valid && !(f_opc == `BIFD_OPC_JAL || f_opc == `BIFD_OPC_JALR ||
                                 f_opc == `BIFD_OPC_BRANCH)) begin
      s_d.pc = s_q.pc + 32'h0000_0004;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q       <= '0;
      s_q.pc    <= RESET_VEC;
      s_q.fmt   <= BIFD_FMT_NOP;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign dec_valid                = s_q.valid;
  assign dec_fmt                  = s_q.fmt;
  assign dec_opcode               = s_q.opc;
  assign dec_rd                   = s_q.rd;
  assign dec_first_source_field   = s_q.rs_a;
  assign dec_second_source_field  = s_q.rs_b;
  assign dec_minor_function_field = s_q.f3;
  assign dec_major_function_field = s_q.f7;
  assign dec_imm                  = s_q.imm;
  assign dec_src_a                = s_q.src_a;
  assign dec_src_b                = s_q.src_b;
  assign dec_pc                   = s_q.dpc;
  assign dec_link_hint            = s_q.link;
  assign exc_illegal              = s_q.illegal;
  assign exc_trap_call            = s_q.trap;
  assign exc_misaligned           = s_q.misal;
  assign exc_pc                   = s_q.epc;
  assign program_counter          = s_q.pc;

  // ==========================================================
  // Checks
  a_misal_on_taken: assert property (@(posedge clk) disable iff (rst)
    xfer_valid && xfer_taken && align_bad |=> exc_misaligned && exc_pc == $past(program_counter))
    else $error("misaligned target not reported on transfer");
  a_misal_pc_held: assert property (@(posedge clk) disable iff (rst)
    xfer_valid && xfer_taken && align_bad |=> $stable(program_counter))
    else $error("pc moved to misaligned target");
  a_untaken_quiet: assert property (@(posedge clk) disable iff (rst)
    xfer_valid && !xfer_taken |=> !exc_misaligned && program_counter == $past(program_counter) + 32'h0000_0004)
    else $error("untaken branch misbehaved");
  // Only meaningful when the reset vector itself is word aligned
  a_pc_aligned: assert property (@(posedge clk) disable iff (rst)
    !SHORT_INSNS && RESET_VEC[1:0] == 2'h0 |-> program_counter[1:0] == 2'h0)
    else $error("pc lost word alignment");
  a_short_align: assert property (@(posedge clk) disable iff (rst)
    SHORT_INSNS && xfer_valid && xfer_taken && !xfer_target[0] |=> !exc_misaligned)
    else $error("halfword target flagged misaligned");
  a_ctl_holds_pc: assert property (@(posedge clk) disable iff (rst)
    insn_valid && !xfer_valid &&
    (f_opc == `BIFD_OPC_JAL || f_opc == `BIFD_OPC_JALR || f_opc == `BIFD_OPC_BRANCH) |=>
    $stable(program_counter))
    else $error("pc moved before transfer resolved");
  a_store_imm: assert property (@(posedge clk) disable iff (rst)
    insn_valid && f_opc == `BIFD_OPC_STORE && insn[1:0] == 2'h3 |=>
    dec_imm == {{20{$past(insn[31])}}, $past(insn[31:25]), $past(insn[11:7])})
    else $error("store immediate wrong");
  a_upper_imm: assert property (@(posedge clk) disable iff (rst)
    insn_valid && f_opc == `BIFD_OPC_LUI |=> dec_imm[11:0] == 12'h000 && dec_imm[31:12] == $past(insn[31:12]))
    else $error("upper immediate wrong");
  a_sign_src: assert property (@(posedge clk) disable iff (rst)
    insn_valid && f_opc == `BIFD_OPC_OPIMM |=> dec_imm[31:11] == {21{$past(insn[31])}})
    else $error("sign not from bit 31");
  a_csr_imm_zext: assert property (@(posedge clk) disable iff (rst)
    insn_valid && f_opc == `BIFD_OPC_SYSTEM && f_f3[`BIFD_F3_CSR_IMM_BIT] |=>
    dec_imm == {27'h0, $past(insn[19:15])})
    else $error("csr immediate not zero extended");
  a_call_traps: assert property (@(posedge clk) disable iff (rst)
    insn_valid && f_opc == `BIFD_OPC_SYSTEM && f_f3 == 3'h0 |=> exc_trap_call && dec_fmt == BIFD_FMT_SYS)
    else $error("system call did not trap");
  a_barrier_nop: assert property (@(posedge clk) disable iff (rst)
    insn_valid && f_opc == `BIFD_OPC_MEMORY_ORDERING_BARRIER |=> dec_fmt == BIFD_FMT_NOP && !exc_illegal && !exc_trap_call)
    else $error("barrier not decoded as no-op");
  a_short_word_bad: assert property (@(posedge clk) disable iff (rst)
    insn_valid && insn[1:0] != 2'h3 |=> dec_fmt == BIFD_FMT_BAD && exc_illegal == RESERVED_IS_ILLEGAL)
    else $error("non 32-bit encoding not refused");
  a_link_seen: assert property (@(posedge clk) disable iff (rst)
    insn_valid && f_opc == `BIFD_OPC_JAL && insn[1:0] == 2'h3 && f_rd == 5'h01 |=> dec_link_hint)
    else $error("link register hint missing");
  a_zero_src: assert property (@(posedge clk) disable iff (rst)
    insn_valid && f_rs_a == 5'h00 |=> dec_src_a == 32'h0000_0000)
    else $error("zero register operand nonzero");
  a_fields_fixed: assert property (@(posedge clk) disable iff (rst)
    insn_valid |=> dec_first_source_field == $past(insn[19:15]) && dec_rd == $past(insn[11:7]))
    else $error("register field misplaced");
  a_reset_vec: assert property (@(posedge clk) $rose(!rst) |-> program_counter == RESET_VEC)
    else $error("pc not at reset vector");

  c_taken_ok:   cover property (@(posedge clk) xfer_valid && xfer_taken && !align_bad);
  c_taken_bad:  cover property (@(posedge clk) xfer_valid && xfer_taken && align_bad);
  c_not_taken:  cover property (@(posedge clk) xfer_valid && !xfer_taken);
  c_store_seen: cover property (@(posedge clk) insn_valid && f_opc == `BIFD_OPC_STORE);
endmodule

// ==== bifd_exec_model.sv ====
// Execute-side model that resolves decoded control transfers
`timescale 1ns/100ps
module bifd_exec_model
  import bifd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        dec_valid,
  input  wire bifd_fmt_t   dec_fmt,
  input  wire logic        cmd_taken,
  input  wire logic [31:0] cmd_target,
  input  wire logic [3:0]  cmd_delay,
  output logic             xfer_valid,
  output logic             xfer_taken,
  output logic [31:0]      xfer_target
);
  logic [3:0] wait_q;
  logic       busy_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q      <= 1'b0;
      wait_q      <= 4'h0;
      xfer_valid  <= 1'b0;
      xfer_taken  <= 1'b0;
      xfer_target <= 32'h0000_0000;
    end else begin
      xfer_valid <= 1'b0;
      if (xfer_valid) begin
        // Qualifiers are stale once released, so never leave the old value up
        xfer_taken  <= ~xfer_taken;
        xfer_target <= ~xfer_target;
      end
      if (dec_valid && dec_fmt == BIFD_FMT_CTL) begin
        busy_q <= 1'b1;
        wait_q <= cmd_delay;
      end else if (busy_q) begin
        if (wait_q == 4'h0) begin
          busy_q      <= 1'b0;
          xfer_valid  <= 1'b1;
          xfer_taken  <= cmd_taken;
          xfer_target <= cmd_target;
        end else begin
          wait_q <= wait_q - 4'h1;
        end
      end
    end
  end
endmodule

// ==== base_integer_format_decode_test.sv ====
// Self-checking bench for the base integer format decoder
`timescale 1ns/100ps
module base_integer_format_decode_test
  import bifd_pkg::*;
;
  // =========================================================
  // Signals
  localparam logic [31:0] RST_PC = 32'h0000_1000;
  logic        clk, rst, insn_valid, xfer_valid, xfer_taken, wb_en, cmd_taken;
  logic [31:0] insn, xfer_target, wb_data, cmd_target, exp_pc, src_a, src_b, dpc, imm, exc_pc, pc;
  logic [4:0]  wb_addr, rd, rs1, rs2;
  logic [3:0]  cmd_delay;
  logic [2:0]  f3;
  logic [6:0]  opc, f7;
  logic        dvalid, hint, illegal, trap, misal, misal16;
  logic [31:0] pc16;
  bifd_fmt_t   fmt;
  int          error_cnt, total_checks;

  bifd_decode #(.SHORT_INSNS(1'b0), .RESET_VEC(RST_PC)) i_bifd_decode (
    .clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn), .xfer_valid(xfer_valid),
    .xfer_taken(xfer_taken), .xfer_target(xfer_target), .wb_en(wb_en), .wb_addr(wb_addr),
    .wb_data(wb_data), .dec_valid(dvalid), .dec_fmt(fmt), .dec_opcode(opc), .dec_rd(rd),
    .dec_first_source_field(rs1), .dec_second_source_field(rs2), .dec_minor_function_field(f3),
    .dec_major_function_field(f7), .dec_imm(imm), .dec_src_a(src_a), .dec_src_b(src_b),
    .dec_pc(dpc), .dec_link_hint(hint), .exc_illegal(illegal), .exc_trap_call(trap),
    .exc_misaligned(misal), .exc_pc(exc_pc), .program_counter(pc));

  // Same stream with halfword alignment, only its alignment behaviour is judged
  bifd_decode #(.SHORT_INSNS(1'b1), .RESET_VEC(RST_PC)) i_bifd_decode_short (
    .clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn), .xfer_valid(xfer_valid),
    .xfer_taken(xfer_taken), .xfer_target(xfer_target), .wb_en(wb_en), .wb_addr(wb_addr),
    .wb_data(wb_data), .dec_valid(), .dec_fmt(), .dec_opcode(), .dec_rd(),
    .dec_first_source_field(), .dec_second_source_field(), .dec_minor_function_field(),
    .dec_major_function_field(), .dec_imm(), .dec_src_a(), .dec_src_b(),
    .dec_pc(), .dec_link_hint(), .exc_illegal(), .exc_trap_call(),
    .exc_misaligned(misal16), .exc_pc(), .program_counter(pc16));

  bifd_exec_model i_bifd_exec_model (
    .clk(clk), .rst(rst), .dec_valid(dvalid), .dec_fmt(fmt), .cmd_taken(cmd_taken),
    .cmd_target(cmd_target), .cmd_delay(cmd_delay), .xfer_valid(xfer_valid),
    .xfer_taken(xfer_taken), .xfer_target(xfer_target));

  // =========================================================
  // Common tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    exp_pc = RST_PC;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_en   <= 1'b1;
    wb_addr <= a;
    wb_data <= d;
    @(posedge clk);
    wb_en   <= 1'b0;
  endtask

  task automatic decode(input logic [31:0] w);
    @(posedge clk);
    insn_valid <= 1'b1;
    insn       <= w;
    @(posedge clk);
    insn_valid <= 1'b0;
    insn       <= ~w;
    #1;
    chk("dec_valid", {31'h0, dvalid}, 32'h1);
  endtask

  task automatic imm1(input logic [31:0] w, input bifd_fmt_t f, input logic [31:0] im);
    decode(w);
    exp_pc = exp_pc + 32'h0000_0004;
    chk("fmt", {29'h0, fmt}, {29'h0, f});
    chk("imm", imm, im);
    chk("opcode", {25'h0, opc}, {25'h0, w[6:0]});
    chk("pc", pc, exp_pc);
    chk("dec_pc", dpc, exp_pc - 32'h0000_0004);
  endtask

  // Waits for the execute model to settle the transfer
  task automatic ctl(input logic [31:0] w, input logic tk, input logic [31:0] tgt, input logic [3:0] dly);
    int n;
    @(posedge clk);
    cmd_taken  <= tk;
    cmd_target <= tgt;
    cmd_delay  <= dly;
    decode(w);
    n = 0;
    while (xfer_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk("resolved", {31'h0, n < 20}, 32'h1);
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // =========================================================
  // Scenarios
  task automatic t_regs();
    do_reset();
    chk("reset_pc", pc, RST_PC);
    chk("reset_fmt", {29'h0, fmt}, {29'h0, BIFD_FMT_NOP});
    wr(5'h05, 32'hdead_beef);
    wr(5'h00, 32'h1234_5678);
    wr(5'h1f, 32'h8000_0001);
    decode({7'h20, 5'h00, 5'h05, 3'h7, 5'h1f, 7'h33});
    chk("src_a", src_a, 32'hdead_beef);
    chk("src_b", src_b, 32'h0000_0000);
    chk("rd", {27'h0, rd}, 32'h0000_001f);
    chk("f3", {29'h0, f3}, 32'h0000_0007);
    chk("f7", {25'h0, f7}, 32'h0000_0020);
    decode({7'h00, 5'h05, 5'h1f, 3'h0, 5'h00, 7'h33});
    chk("src_a", src_a, 32'h8000_0001);
    chk("src_b", src_b, 32'hdead_beef);
    chk("rs1", {27'h0, rs1}, 32'h0000_001f);
    chk("rs2", {27'h0, rs2}, 32'h0000_0005);
    $display("Test registers done");
  endtask

  task automatic t_imm();
    do_reset();
    imm1({12'hffe, 5'h01, 3'h0, 5'h02, 7'h13}, BIFD_FMT_I, 32'hffff_fffe);
    imm1({12'h7ff, 5'h01, 3'h2, 5'h02, 7'h03}, BIFD_FMT_I, 32'h0000_07ff);
    imm1({7'h40, 5'h03, 5'h04, 3'h2, 5'h15, 7'h23}, BIFD_FMT_S, 32'hffff_f815);
    imm1({7'h3f, 5'h03, 5'h04, 3'h0, 5'h0a, 7'h23}, BIFD_FMT_S, 32'h0000_07ea);
    imm1({20'h8_1234, 5'h09, 7'h37}, BIFD_FMT_U, 32'h8123_4000);
    imm1({20'h0_0001, 5'h09, 7'h17}, BIFD_FMT_U, 32'h0000_1000);
    $display("Test immediates done");
  endtask

  task automatic t_sys();
    do_reset();
    decode(32'h0000_0073);
    chk("trap", {31'h0, trap}, 32'h1);
    chk("fmt", {29'h0, fmt}, {29'h0, BIFD_FMT_SYS});
    decode(32'h0010_0073);
    chk("trap", {31'h0, trap}, 32'h1);
    decode({12'hfff, 5'h1f, 3'h5, 5'h01, 7'h73});
    chk("csr_imm", imm, 32'h0000_001f);
    chk("trap", {31'h0, trap}, 32'h0);
    decode(32'h0ff0_000f);
    chk("fmt", {29'h0, fmt}, {29'h0, BIFD_FMT_NOP});
    chk("illegal", {31'h0, illegal}, 32'h0);
    decode(32'h0000_0000);
    chk("illegal", {31'h0, illegal}, 32'h1);
    decode(32'h0000_0013);
    chk("illegal", {31'h0, illegal}, 32'h0);
    $display("Test system done");
  endtask

  task automatic t_ctl();
    do_reset();
    imm1(32'h0000_0013, BIFD_FMT_I, 32'h0000_0000);
    ctl(32'h0000_00ef, 1'b1, RST_PC + 32'h0000_0100, 4'h0);
    chk("link_hint", {31'h0, hint}, 32'h1);
    chk("pc", pc, RST_PC + 32'h0000_0100);
    chk("misal", {31'h0, misal}, 32'h0);
    ctl(32'h0002_8067, 1'b1, RST_PC + 32'h0000_0202, 4'h3);
    chk("link_hint", {31'h0, hint}, 32'h1);
    chk("misal", {31'h0, misal}, 32'h1);
    chk("exc_pc", exc_pc, RST_PC + 32'h0000_0100);
    chk("pc", pc, RST_PC + 32'h0000_0100);
    chk("misal16", {31'h0, misal16}, 32'h0);
    chk("pc16", pc16, RST_PC + 32'h0000_0202);
    ctl(32'h0031_8063, 1'b0, RST_PC + 32'h0000_0302, 4'h1);
    chk("misal", {31'h0, misal}, 32'h0);
    chk("pc", pc, RST_PC + 32'h0000_0104);
    chk("link_hint", {31'h0, hint}, 32'h0);
    chk("exc_pc", exc_pc, RST_PC + 32'h0000_0100);
    ctl(32'h0000_00ef, 1'b1, RST_PC + 32'h0000_0105, 4'h2);
    chk("misal", {31'h0, misal}, 32'h1);
    chk("exc_pc", exc_pc, RST_PC + 32'h0000_0104);
    chk("misal16", {31'h0, misal16}, 32'h1);
    chk("pc16", pc16, RST_PC + 32'h0000_0206);
    $display("Test control transfers done");
  endtask

  // =========================================================
  // Clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    insn_valid = 1'b0;
    insn = 32'h0000_0000;
    wb_en = 1'b0;
    wb_addr = 5'h00;
    wb_data = 32'h0000_0000;
    cmd_taken = 1'b0;
    cmd_target = 32'h0000_0000;
    cmd_delay = 4'h0;
    error_cnt = 0;
    total_checks = 0;
    t_regs();
    t_imm();
    t_sys();
    t_ctl();
    finish_test();
  end

  // The whole run needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
